// *** verilog/asrm_pkg.sv ***
// Contract
// - Identity: family byte, 48-bit serial, check byte
// - Check byte is CRC-8 over first 56 bits
// - CRC-8 starts at zero, bits fed LSB first
// - ROM command must precede memory commands
// - Every byte travels least significant bit first
// - Data memory is four 32-byte pages, 00h-7Fh
// - Status bytes 0-6 OTP, byte 7 volatile
// - Writes pass through the 8-bit scratchpad
// - CRC-16 returned over command, address, data
// - Commit by program pulse or dummy FFh
// - Conditional search answers only when condition met
// - Drive two open-drain switches, report sensed levels
// - Status 7 holds selection, flip-flops, supply bit
// - Programmed protect bit locks its data page
package asrm_pkg;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned DATA_BYTES = 128;
  localparam int unsigned STAT_BYTES = 8;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned APB_DW = 32;
  localparam logic [15:0] DATA_END = 16'h007f;
  localparam logic [15:0] STAT_END = 16'h0007;
  localparam logic [15:0] STAT_RAM_ADDR = 16'h0007;
  localparam logic [7:0] CRC8_POLY = 8'h8c;
  localparam logic [15:0] CRC16_POLY = 16'ha001;
  localparam logic [7:0] CMD_READ_ROM = 8'h33;
  localparam logic [7:0] CMD_MATCH = 8'h55;
  localparam logic [7:0] CMD_SEARCH = 8'hf0;
  localparam logic [7:0] CMD_SKIP = 8'hcc;
  localparam logic [7:0] CMD_COND = 8'hec;
  localparam logic [7:0] CMD_RD_MEM = 8'hf0;
  localparam logic [7:0] CMD_WR_MEM = 8'h0f;
  localparam logic [7:0] CMD_RD_STAT = 8'haa;
  localparam logic [7:0] CMD_WR_STAT = 8'h55;
  localparam logic [7:0] CMD_CHAN = 8'hf5;
  localparam logic [7:0] COMMIT_BYTE = 8'hff;
  localparam logic [7:0] OTP_RESET = 8'hff;
  localparam logic [7:0] TEST_RESET = 8'h00;
  localparam logic [6:0] ST7_RESET = 7'h7f;
  localparam int unsigned ST_PROT = 0;
  localparam int unsigned ST_TEST = 5;
  localparam int unsigned ST_SIX = 6;
  localparam int unsigned ST_RAM = 7;
  localparam int unsigned ST7_POL = 0;
  localparam int unsigned ST7_SRC = 1;
  localparam int unsigned ST7_CHN = 3;
  localparam int unsigned ST7_FFA = 5;
  localparam int unsigned ST7_FFB = 6;
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_STAT = 12'h004;
  localparam logic [11:0] REG_ID_LO = 12'h008;
  localparam logic [11:0] REG_ID_HI = 12'h00c;
  localparam int unsigned CTRL_SUP = 0;
  localparam int unsigned CTRL_EN = 1;
  localparam logic [1:0] CTRL_RESET = 2'h2;
  typedef enum logic [3:0] {
    S_ROM, S_MATCH, S_ID_SEND, S_MEMCMD, S_ADDR_LO, S_ADDR_HI, S_DATA,
    S_CRC_LO, S_CRC_HI, S_COMMIT, S_READ, S_CHAN, S_IDLE
  } asrm_state_e;
endpackage

// *** verilog/asrm_crc_byte.sv ***
module asrm_crc_byte #(
  parameter int unsigned W = 8,
  parameter logic [W-1:0] POLY = '0
) (
  input wire logic [W-1:0] crc_in,
  input wire logic [7:0] data,
  output logic [W-1:0] crc_out
);
  // Reflected shift-register form: bit 0 of the byte enters first
  always_comb begin
    logic [W-1:0] c;
    logic fb;
    c = crc_in;
    fb = 1'b0;
    for (int i = 0; i < 8; i++) begin
      fb = c[0] ^ data[i];
      c = c >> 1;
      if (fb) begin
        c = c ^ POLY;
      end
    end
    crc_out = c;
  end
endmodule

// *** verilog/asrm_fifo.sv ***
module asrm_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 32,
  parameter int unsigned AW = $clog2(DEPTH)
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  logic [AW:0] cnt_q, cnt_d;
  logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic push, pop;

  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;

  always_comb begin
    wr_d = push ? wr_q + 1'b1 : wr_q;
    rd_d = pop ? rd_q + 1'b1 : rd_q;
    cnt_d = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      wr_q <= '0;
      rd_q <= '0;
    end else if (ce) begin
      cnt_q <= cnt_d;
      wr_q <= wr_d;
      rd_q <= rd_d;
    end
  end

  // Storage carries no reset: only valid entries are ever read
  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule

// *** verilog/asrm_top.sv ***
// The APB interface to the registers and the register offsets were left to the implementer.
module asrm_top #(
  parameter logic [7:0] FAMILY = 8'h5a,          // Arbitrary value
  parameter logic [47:0] SERIAL = 48'h0000_0000_0001 // Arbitrary value
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [asrm_pkg::APB_AW-1:0] paddr,
  input wire logic [asrm_pkg::APB_DW-1:0] pwdata,
  output logic [asrm_pkg::APB_DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic link_reset,
  input wire logic prog_pulse,
  input wire logic rx_valid,
  input wire logic [asrm_pkg::BYTE_W-1:0] rx_data,
  output logic rx_ready,
  output logic tx_valid,
  output logic [asrm_pkg::BYTE_W-1:0] tx_data,
  input wire logic tx_ready,
  input wire logic switch_channel_a_i,
  output logic switch_channel_a_o,
  output logic switch_channel_a_oe,
  input wire logic switch_channel_b_i,
  output logic switch_channel_b_o,
  output logic switch_channel_b_oe
);
  import asrm_pkg::*;

  asrm_state_e state_q, state_d;
  logic [2:0] cnt_q, cnt_d, init_q, init_d;
  logic [15:0] addr_q, addr_d, crc16_q, crc16_d, crc16_in, crc16_out;
  logic [7:0] cmd_q, cmd_d, scratch_q, scratch_d, idcrc_q, idcrc_d;
  logic [7:0] crc8_in, crc8_out, push_data, rd_byte, chan_info, st7;
  logic mism_q, mism_d, rx_ready_q, rx_ready_d;
  logic [1:0] ctrl_q, ctrl_d, act_q, act_d, sense_q, oe_q, oe_d, pin_o_q;
  logic pready_q, pready_d, pslverr_q, pslverr_d;
  logic [31:0] prdata_q, prdata_d;
  logic [7:0] data_q [DATA_BYTES];
  logic [7:0] stat_q [STAT_BYTES];
  logic id_ready, rx_take, push, fifo_in_ready, store_en, cond_met;
  logic is_stat, is_write, in_range, at_end, ram_tgt, prot, done, id_ok;
  logic [1:0] cv;
  logic [63:0] id_code;

  ////////////////////////////////////////////////////////////////////////
  // Identity code and its check byte, built once after reset
  assign id_code = {idcrc_q, SERIAL, FAMILY};
  assign id_ready = (init_q == 3'd7);
  assign crc8_in = (init_q == 3'd0) ? 8'h00 : idcrc_q;

  function automatic logic [7:0] id_byte(input logic [2:0] i,
                                         input logic [63:0] id);
    return id[{i, 3'b000} +: 8];
  endfunction

  asrm_crc_byte #(.W(8), .POLY(CRC8_POLY)) u_crc8 (
    .crc_in(crc8_in),
    .data(id_byte(init_q, id_code)),
    .crc_out(crc8_out)
  );

  always_comb begin
    init_d = id_ready ? init_q : init_q + 3'd1;
    idcrc_d = id_ready ? idcrc_q : crc8_out;
  end

  ////////////////////////////////////////////////////////////////////////
  // Conditional search selection and channel reporting
  assign st7 = {ctrl_q[CTRL_SUP], stat_q[ST_RAM][6:0]};
  always_comb begin
    case (st7[ST7_SRC +: 2])
      2'b01: cv = {st7[ST7_FFB], st7[ST7_FFA]};
      2'b10: cv = sense_q;
      2'b11: cv = act_q;
      default: cv = 2'b00;
    endcase
    case (st7[ST7_CHN +: 2])
      2'b01: cond_met = (cv[0] == st7[ST7_POL]);
      2'b10: cond_met = (cv[1] == st7[ST7_POL]);
      2'b11: cond_met = ((cv[0] | cv[1]) == st7[ST7_POL]);
      default: cond_met = 1'b0;
    endcase
    if (st7[ST7_SRC +: 2] == 2'b00) begin
      cond_met = 1'b0;
    end
  end
  assign chan_info = {st7[7], 1'b0, act_q, sense_q,
                      st7[ST7_FFB], st7[ST7_FFA]};

  ////////////////////////////////////////////////////////////////////////
  // Memory decode
  assign is_stat = (cmd_q == CMD_RD_STAT) || (cmd_q == CMD_WR_STAT);
  assign is_write = (cmd_q == CMD_WR_MEM) || (cmd_q == CMD_WR_STAT);
  assign in_range = addr_q <= (is_stat ? STAT_END : DATA_END);
  assign at_end = addr_q == (is_stat ? STAT_END : DATA_END);
  assign ram_tgt = is_stat && (addr_q == STAT_RAM_ADDR);
  assign prot = !is_stat && !stat_q[ST_PROT][addr_q[6:5]];
  assign rd_byte = is_stat ? ((addr_q[2:0] == 3'd7) ? st7 :
                   stat_q[addr_q[2:0]]) : data_q[addr_q[6:0]];
  assign rx_take = rx_valid & rx_ready_q;
  assign crc16_in = (state_q == S_MEMCMD) ? 16'h0000 : crc16_q;

  asrm_crc_byte #(.W(16), .POLY(CRC16_POLY)) u_crc16 (
    .crc_in(crc16_in),
    .data(rx_data),
    .crc_out(crc16_out)
  );

  ////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    addr_d = addr_q;
    cmd_d = cmd_q;
    scratch_d = scratch_q;
    crc16_d = crc16_q;
    mism_d = mism_q;
    id_ok = rx_data == id_byte(cnt_q, id_code);
    push = 1'b0;
    push_data = 8'h00;
    store_en = 1'b0;
    case (state_q)
      S_ROM: if (rx_take) begin
        cnt_d = 3'd0;
        mism_d = 1'b0;
        case (rx_data)
          CMD_READ_ROM, CMD_SEARCH: state_d = S_ID_SEND;
          CMD_COND: state_d = cond_met ? S_ID_SEND : S_IDLE;
          CMD_MATCH: state_d = S_MATCH;
          CMD_SKIP: state_d = S_MEMCMD;
          default: state_d = S_IDLE;
        endcase
      end
      S_MATCH: if (rx_take) begin
        mism_d = mism_q | !id_ok;
        cnt_d = cnt_q + 3'd1;
        if (cnt_q == 3'd7) begin
          state_d = (mism_q || !id_ok) ? S_IDLE : S_MEMCMD;
        end
      end
      S_ID_SEND: begin
        push = 1'b1;
        push_data = id_byte(cnt_q, id_code);
        if (fifo_in_ready) begin
          cnt_d = cnt_q + 3'd1;
          if (cnt_q == 3'd7) begin
            state_d = S_MEMCMD;
          end
        end
      end
      S_MEMCMD: if (rx_take) begin
        cmd_d = rx_data;
        crc16_d = crc16_out;
        case (rx_data)
          CMD_RD_MEM, CMD_RD_STAT, CMD_WR_MEM, CMD_WR_STAT:
            state_d = S_ADDR_LO;
          CMD_CHAN: state_d = S_CHAN;
          default: state_d = S_IDLE;
        endcase
      end
      S_ADDR_LO: if (rx_take) begin
        addr_d[7:0] = rx_data;
        crc16_d = crc16_out;
        state_d = S_ADDR_HI;
      end
      S_ADDR_HI: if (rx_take) begin
        addr_d[15:8] = rx_data;
        crc16_d = crc16_out;
        state_d = is_write ? S_DATA : S_READ;
      end
      S_DATA: if (rx_take) begin
        scratch_d = rx_data;
        crc16_d = crc16_out;
        state_d = S_CRC_LO;
      end
      S_CRC_LO: begin
        push = 1'b1;
        push_data = ~crc16_q[7:0];
        if (fifo_in_ready) begin
          state_d = S_CRC_HI;
        end
      end
      S_CRC_HI: begin
        push = 1'b1;
        push_data = ~crc16_q[15:8];
        if (fifo_in_ready) begin
          state_d = S_COMMIT;
        end
      end
      S_COMMIT: if (ram_tgt) begin
        if (rx_take && rx_data == COMMIT_BYTE) begin
          store_en = 1'b1;
          state_d = S_IDLE;
        end
      end else if (prog_pulse) begin
        store_en = in_range;
        state_d = S_IDLE;
      end
      S_READ: if (!in_range) begin
        state_d = S_IDLE;
      end else begin
        push = 1'b1;
        push_data = rd_byte;
        if (fifo_in_ready) begin
          addr_d = addr_q + 16'h0001;
          if (at_end) begin
            state_d = S_IDLE;
          end
        end
      end
      S_CHAN: begin
        push = 1'b1;
        push_data = chan_info;
        if (fifo_in_ready) begin
          state_d = S_IDLE;
        end
      end
      S_IDLE: state_d = S_IDLE;
      default: state_d = S_ROM;
    endcase
    // Scratchpad is left as is; only the commit state stores it
    if (link_reset || !id_ready || !ctrl_q[CTRL_EN]) begin
      state_d = S_ROM;
    end
  end

  always_comb begin
    case (state_d)
      S_ID_SEND, S_CRC_LO, S_CRC_HI, S_READ, S_CHAN: rx_ready_d = 1'b0;
      default: rx_ready_d = id_ready & ctrl_q[CTRL_EN] & !link_reset;
    endcase
    // Set wins over the clear from a channel access
    act_d = ((state_q == S_CHAN && fifo_in_ready) ? 2'b00 : act_q) |
            (sense_q ^ {switch_channel_b_i, switch_channel_a_i});
    oe_d = ~{stat_q[ST_RAM][ST7_FFB], stat_q[ST_RAM][ST7_FFA]};
  end

  ////////////////////////////////////////////////////////////////////////
  // APB slave, one wait state on every access
  always_comb begin
    done = psel & penable & pready_q;
    pready_d = psel & penable & ~pready_q;
    ctrl_d = (done && pwrite && paddr == REG_CTRL) ? pwdata[1:0] : ctrl_q;
    prdata_d = prdata_q;
    pslverr_d = 1'b0;
    if (pready_d) begin
      prdata_d = 32'h0000_0000;
      case (paddr)
        REG_CTRL: prdata_d[1:0] = ctrl_q;
        REG_STAT: prdata_d[8:0] = {id_ready, cond_met, act_q, sense_q,
                                   st7[ST7_FFB], st7[ST7_FFA], ram_tgt};
        REG_ID_LO: prdata_d = id_code[31:0];
        REG_ID_HI: prdata_d = id_code[63:32];
        default: pslverr_d = 1'b1;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= S_ROM;
      cnt_q <= 3'd0;
      init_q <= 3'd0;
      addr_q <= 16'h0000;
      cmd_q <= 8'h00;
      scratch_q <= 8'h00;
      crc16_q <= 16'h0000;
      idcrc_q <= 8'h00;
      mism_q <= 1'b0;
      rx_ready_q <= 1'b0;
      ctrl_q <= CTRL_RESET;
      act_q <= 2'b00;
      // Pins idle high with both switches off; avoids a false activity edge
      sense_q <= 2'b11;
      oe_q <= 2'b00;
      pin_o_q <= 2'b00;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
    end else if (ce) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      init_q <= init_d;
      addr_q <= addr_d;
      cmd_q <= cmd_d;
      scratch_q <= scratch_d;
      crc16_q <= crc16_d;
      idcrc_q <= idcrc_d;
      mism_q <= mism_d;
      rx_ready_q <= rx_ready_d;
      ctrl_q <= ctrl_d;
      act_q <= act_d;
      sense_q <= {switch_channel_b_i, switch_channel_a_i};
      oe_q <= oe_d;
      pin_o_q <= 2'b00;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // OTP cells reset to erased, status bytes 5 and 6 to 00h, as a stand-in for non-volatile storage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DATA_BYTES; i++) begin
        data_q[i] <= OTP_RESET;
      end
      for (int i = 0; i < STAT_BYTES; i++) begin
        stat_q[i] <= OTP_RESET;
      end
      stat_q[ST_TEST] <= TEST_RESET;
      stat_q[ST_SIX] <= TEST_RESET;
      stat_q[ST_RAM] <= {1'b0, ST7_RESET};
    end else if (ce && store_en) begin
      if (!is_stat) begin
        if (!prot) begin
          data_q[addr_q[6:0]] <= data_q[addr_q[6:0]] & scratch_q;
        end
      end else if (ram_tgt) begin
        stat_q[ST_RAM] <= {1'b0, scratch_q[6:0]};
      end else begin
        stat_q[addr_q[2:0]] <= stat_q[addr_q[2:0]] & scratch_q;
      end
    end
  end

  asrm_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .in_valid(push),
    .in_ready(fifo_in_ready),
    .in_data(push_data),
    .out_valid(tx_valid),
    .out_ready(tx_ready),
    .out_data(tx_data)
  );

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign rx_ready = rx_ready_q;
  assign switch_channel_a_oe = oe_q[0];
  assign switch_channel_b_oe = oe_q[1];
  assign switch_channel_a_o = pin_o_q[0];
  assign switch_channel_b_o = pin_o_q[1];

  ////////////////////////////////////////////////////////////////////////
  rom_first_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_q == S_ROM |=> !(state_q inside {S_ADDR_LO, S_READ,
    S_DATA, S_CHAN})) else $error("memory state entered from ROM level");
  bus_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && link_reset |=> state_q == S_ROM && !rx_ready)
    else $error("bus reset did not abort");
  scratch_load_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_q == S_DATA && rx_take |=> state_q == S_CRC_LO &&
    scratch_q == $past(rx_data)) else $error("scratchpad not loaded");
  crc_send_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_q == S_CRC_LO |-> push && push_data == ~crc16_q[7:0])
    else $error("CRC low byte wrong");
  ram_commit_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_q == S_COMMIT && ram_tgt && rx_take && rx_data == 8'hff
    |=> stat_q[7][6:0] == $past(scratch_q[6:0]) && state_q == S_IDLE)
    else $error("volatile commit failed");
  otp_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && store_en && !is_stat |=> (data_q[$past(addr_q[6:0])] &
    ~$past(data_q[addr_q[6:0]])) == 8'h00) else $error("OTP bit set");
  page_lock_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && store_en && prot |=> data_q[$past(addr_q[6:0])] ==
    $past(data_q[addr_q[6:0]])) else $error("protected page written");
  cond_skip_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce && state_q == S_ROM && rx_take && rx_data == 8'hec && !cond_met &&
    !link_reset && ctrl_q[1] |=> state_q == S_IDLE)
    else $error("answered unmet condition");
  switch_drv_a: assert property (@(posedge pclk) disable iff (!presetn)
    ce |=> switch_channel_a_oe == !$past(stat_q[7][5]))
    else $error("switch A drive wrong");
  read_range_a: assert property (@(posedge pclk) disable iff (!presetn)
    push && state_q == S_READ && !is_stat |-> addr_q <= 16'h007f)
    else $error("read beyond data memory");
endmodule

// *** sim/asrm_link_master.sv ***
module asrm_link_master (
  input wire logic pclk,
  output logic rx_valid,
  output logic [7:0] rx_data,
  input wire logic rx_ready,
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  int stall = 0;
  initial begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    tx_ready = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // Whole bytes only; the bit front end shifts them LSB first
  task automatic send(input logic [7:0] v);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= v;
    @(posedge pclk);
    while (rx_ready !== 1'b1) @(posedge pclk);
    rx_valid <= 1'b0;
    // Released data must not look like a held byte
    rx_data <= ~v;
  endtask
  // Slow reader: stall cycles before each byte is accepted
  task automatic recv(output logic [7:0] v);
    repeat (stall) @(posedge pclk);
    @(posedge pclk);
    tx_ready <= 1'b1;
    @(posedge pclk);
    while (tx_valid !== 1'b1) @(posedge pclk);
    v = tx_data;
    tx_ready <= 1'b0;
  endtask
endmodule

// *** sim/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import asrm_pkg::*;
  localparam logic [7:0] FAM = 8'h5a; // Arbitrary value
  localparam logic [47:0] SER = 48'h0000_0000_0001; // Arbitrary value
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [APB_AW-1:0] paddr = '0;
  logic [APB_DW-1:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, link_reset = 0, prog_pulse = 0;
  logic rx_valid, rx_ready, tx_valid, tx_ready, a_pin, b_pin;
  logic sa_o, sa_oe, sb_o, sb_oe;
  logic [7:0] rx_data, tx_data, b;
  logic [63:0] id;
  logic [7:0] q[$];
  int err_total = 0, total_checks = 0, cyc = 0;
  // Open-drain pins: pulled up unless a transistor conducts
  assign a_pin = sa_oe ? 1'b0 : 1'b1;
  assign b_pin = sb_oe ? 1'b0 : 1'b1;
  initial forever #50 pclk = ~pclk;
  asrm_top #(.FAMILY(FAM), .SERIAL(SER)) DUT (
    .pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_reset(link_reset), .prog_pulse(prog_pulse),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_ready(tx_ready),
    .switch_channel_a_i(a_pin), .switch_channel_a_o(sa_o),
    .switch_channel_a_oe(sa_oe), .switch_channel_b_i(b_pin),
    .switch_channel_b_o(sb_o), .switch_channel_b_oe(sb_oe));
  asrm_link_master m (.pclk(pclk), .rx_valid(rx_valid),
    .rx_data(rx_data), .rx_ready(rx_ready), .tx_valid(tx_valid),
    .tx_data(tx_data), .tx_ready(tx_ready));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] crc8(input logic [63:0] v, input int n);
    logic [7:0] c;
    c = 8'h00;
    // X^8 + X^5 + X^4 + 1 in shift-right form
    for (int i = 0; i < n; i++)
      c = ((c[0] ^ v[i]) ? 8'h8c : 8'h00) ^ (c >> 1);
    return c;
  endfunction
  function automatic logic [15:0] crc16(input logic [31:0] v);
    logic [15:0] c;
    c = 16'h0000;
    for (int i = 0; i < 32; i++)
      c = ((c[0] ^ v[i]) ? 16'ha001 : 16'h0000) ^ (c >> 1);
    return ~c;
  endfunction
  task automatic test_done();
    if (err_total == 0 && total_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input logic [31:0] got, exp, input string s);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h exp %h", $time, s, got, exp);
    end
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
      err_total++;
      $display("wrong value at %0t: run hung", $time);
      test_done();
    end
  end
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic lreset();
    @(posedge pclk);
    link_reset <= 1'b1;
    @(posedge pclk);
    link_reset <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_apb();
    int n;
    apb(1'b0, REG_CTRL, '0);
    check(rd, 32'h2, "ctrl reset");
    n = 0;
    rd = '0;
    while (rd[8] !== 1'b1 && n < 50) begin
      apb(1'b0, REG_STAT, '0);
      n++;
    end
    check(rd[8], 1'b1, "id ready");
    apb(1'b0, REG_ID_LO, '0);
    check(rd, id[31:0], "id lo");
    apb(1'b0, REG_ID_HI, '0);
    check(rd, id[63:32], "id hi");
    apb(1'b0, 12'h010, '0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b1, REG_CTRL, 32'h3);
    check(err, 1'b0, "ctrl write");
    apb(1'b0, REG_CTRL, '0);
    check(rd, 32'h3, "ctrl readback");
  endtask
  task automatic t_rom();
    logic [63:0] g;
    lreset();
    m.send(CMD_READ_ROM);
    for (int i = 0; i < 8; i++) begin
      m.recv(b);
      g[8*i+:8] = b;
    end
    check(g[31:0], id[31:0], "rom lo");
    check(g[63:32], id[63:32], "rom hi");
    check(crc8(g, 64), 0, "residue");
  endtask
  task automatic t_write(input logic [7:0] cmd, input logic [15:0] a,
                         input logic [7:0] d, input int how);
    logic [15:0] c;
    lreset();
    m.send(CMD_SKIP);
    m.send(cmd);
    m.send(a[7:0]);
    m.send(a[15:8]);
    m.send(d);
    c = crc16({d, a, cmd});
    m.recv(b);
    check(b, c[7:0], "crc lo");
    m.recv(b);
    check(b, c[15:8], "crc hi");
    if (how == 1) begin
      @(posedge pclk);
      prog_pulse <= 1'b1;
      @(posedge pclk);
      prog_pulse <= 1'b0;
    end else if (how == 2)
      m.send(COMMIT_BYTE);
    else
      lreset();
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_read(input logic [7:0] cmd, input logic [15:0] a,
                        input logic [7:0] e[$], input int hold);
    lreset();
    m.send(CMD_SKIP);
    m.send(cmd);
    m.send(a[7:0]);
    m.send(a[15:8]);
    // Far side stalls so the transmit buffer fills and refuses
    repeat (hold) @(posedge pclk);
    foreach (e[i]) begin
      m.recv(b);
      check(b, e[i], "read byte");
    end
  endtask
  task automatic t_stat();
    m.stall = 2;
    t_write(CMD_WR_STAT, 16'h0007, 8'h5f, 2);
    check({sa_oe, sb_oe}, 2'b10, "switch on");
    check({sa_o, sb_o}, 2'b00, "switch data");
    t_read(CMD_RD_STAT, 16'h0000, {8'hf7, 8'hff, 8'hff, 8'hff, 8'hff,
           8'h00, 8'h00, 8'hdf}, 0);
    m.stall = 0;
  endtask
  task automatic t_chan();
    lreset();
    m.send(CMD_SKIP);
    m.send(CMD_CHAN);
    m.recv(b);
    check(b, 8'h9a, "channel byte");
  endtask
  // Selection by a ROM-level command, then a channel access
  task automatic t_sel(input logic [7:0] rom, input logic [63:0] v,
                       input logic ok);
    lreset();
    m.send(rom);
    for (int i = 0; i < 8; i++) begin
      if (rom == CMD_MATCH)
        m.send(v[8*i+:8]);
      else if (ok) begin
        m.recv(b);
        check(b, v[8*i+:8], "id byte");
      end
    end
    m.send(CMD_CHAN);
    if (ok) begin
      m.recv(b);
      check(b, 8'h8a, "select then channel");
    end else begin
      repeat (20) @(posedge pclk);
      check(tx_valid, 1'b0, "no answer");
    end
  endtask
  task automatic t_cond();
    t_sel(CMD_COND, id, 1'b0);
    // Pin level of channel A, polarity 0; flip-flops kept
    t_write(CMD_WR_STAT, 16'h0007, 8'h4c, 2);
    apb(1'b0, REG_STAT, '0);
    check(rd[8:1], 8'hca, "status word");
    t_sel(CMD_COND, id, 1'b1);
    t_sel(CMD_MATCH, id, 1'b1);
    t_sel(CMD_MATCH, id ^ 64'h100, 1'b0);
    t_sel(CMD_SEARCH, id, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    id = {crc8({SER, FAM}, 56), SER, FAM};
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    t_apb();
    t_rom();
    t_write(CMD_WR_MEM, 16'h007e, 8'ha5, 1);
    t_read(CMD_RD_MEM, 16'h007e, {8'ha5, 8'hff}, 0);
    t_write(CMD_WR_MEM, 16'h007e, 8'h5a, 1);
    t_write(CMD_WR_MEM, 16'h007d, 8'h12, 0);
    t_write(CMD_WR_STAT, 16'h0000, 8'hf7, 1);
    t_write(CMD_WR_MEM, 16'h007f, 8'h00, 1);
    for (int i = 0; i < 128; i++)
      q.push_back(i == 126 ? 8'h00 : 8'hff);
    t_read(CMD_RD_MEM, 16'h0000, q, 300);
    t_stat();
    t_chan();
    t_cond();
    test_done();
  end
endmodule
